//--- verilog/gsoi_top.sv
/*
 gsoi_top: output side of a gas sensor module: text frame on serial line, two-wire read slave,
 alarm with hysteresis, pulse-width output and zero calibration control.
 assumes pins synchronous to the clock, readings in percent of range, one reading per measValid.
*/
//Functional notes
//- both pins high: normal measurement, no calibration unless periodic was started by command
//- manual pin low, periodic pin high: zero after 2 minutes
//- periodic zero: 2 days, 5 days, weekly
//- periodic enabled by command or periodic pin low, while manual pin high
//- percent frame is 12 characters, fixed layout
//- zero digit sent as space in percent
//- ppm option: six digits then ppm
//- slave only, seven-bit address 0x31
//- alarm on above 25, off at 10
//- pulse period 2000 ms, high 2+1000*fraction
//- serial 38400 8N1, 9600/19200 selectable
`timescale 1ns/1ns
module gsoi_top
	import gsoi_pkg::*;
#(
	parameter int SEC_CYCLES = CLK_HZ,
	parameter int MS_CYCLES  = CLK_HZ / MS_PER_SEC,
	parameter int FIFO_DEPTH = 16
) (
	// clock and reset
	input  wire logic       clock,
	input  wire logic       rst_n,
	// measurement
	input  wire logic       measValid,
	input  wire logic [6:0] measLel,
	// options
	input  wire logic       ppmMode,
	input  wire logic [1:0] baudSel,
	// calibration
	input  wire logic       manualZeroPin_n,
	input  wire logic       periodicZeroPin_n,
	input  wire logic       autoStartCmd,
	output logic            manualActive_r,
	output logic            autoActive_r,
	output logic            zeroCalReq_r,
	// serial line
	output logic            txd_r,
	// two-wire slave
	input  wire logic       sclIn,
	input  wire logic       sdaIn,
	output logic            sdaOut_r,
	output logic            sdaOe_r,
	// alarm and pulse
	output logic            alarmOe_r,
	output logic            pwmOut_r
);
	if (SEC_CYCLES < 2 || MS_CYCLES < 2 || FIFO_DEPTH < FRAME_LEN) begin : g_badParam
		$error("gsoi_top parameter out of range");
	end

	localparam int BAUD_DIV_DEF  = CLK_HZ / BAUD_DEFAULT;
	localparam int BAUD_DIV_SLOW = CLK_HZ / BAUD_SLOW;
	localparam int BAUD_DIV_MID  = CLK_HZ / BAUD_MID;

	function automatic logic [11:0] baudDiv(input logic [1:0] sel);
		case (sel)
			BAUD_SEL_SLOW: baudDiv = 12'(BAUD_DIV_SLOW - 1);
			BAUD_SEL_MID:  baudDiv = 12'(BAUD_DIV_MID - 1);
			default:       baudDiv = 12'(BAUD_DIV_DEF - 1);
		endcase
	endfunction : baudDiv

	function automatic logic [19:0] autoLimit(input logic [1:0] stage);
		case (stage)
			2'h0:    autoLimit = 20'(AUTO_FIRST_DAYS * SEC_PER_DAY - 1);
			2'h1:    autoLimit = 20'(AUTO_NEXT_DAYS * SEC_PER_DAY - 1);
			default: autoLimit = 20'(AUTO_WEEK_DAYS * SEC_PER_DAY - 1);
		endcase
	endfunction : autoLimit

	function automatic logic [16:0] pow10(input logic [2:0] p);
		case (p)
			3'h0:    pow10 = 17'h00001;
			3'h1:    pow10 = 17'h0000a;
			3'h2:    pow10 = 17'h00064;
			3'h3:    pow10 = 17'h003e8;
			3'h4:    pow10 = 17'h02710;
			default: pow10 = 17'h186a0;
		endcase
	endfunction : pow10

	function automatic logic [7:0] digitChar(input logic [16:0] v, input logic [2:0] p);
		logic [16:0] q;
		q = (v / pow10(p)) % 17'h0000a;
		digitChar = CH_ZERO + 8'(q);
	endfunction : digitChar

	function automatic logic [7:0] frameByte(input logic [3:0] idx, input logic [6:0] v, input logic ppm);
		logic [16:0] pv;
		logic [2:0]  place;
		pv = 17'(15'(v) * PPM_PER_LEL);
		place = 3'(3'h5 - idx[2:0]);
		frameByte = CH_SP;
		if (ppm) begin
			case (idx)
				4'h0, 4'h1, 4'h2, 4'h3, 4'h4:
					frameByte = (pv < pow10(place)) ? CH_SP : digitChar(pv, place);
				4'h5:    frameByte = digitChar(pv, 3'h0);
				4'h7, 4'h8: frameByte = CH_P;
				4'h9:    frameByte = CH_M;
				4'ha:    frameByte = CH_CR;
				4'hb:    frameByte = CH_LF;
				default: frameByte = CH_SP;
			endcase
		end else begin
			case (idx)
				4'h2:    frameByte = (v == FULL_RANGE) ? CH_ONE : CH_SP;
				4'h3, 4'h4: begin
					frameByte = digitChar(17'(v), (idx == 4'h3) ? 3'h1 : 3'h0);
					if (frameByte == CH_ZERO) frameByte = CH_SP;
				end
				4'h5:    frameByte = CH_PCT;
				4'h7, 4'h9: frameByte = CH_L;
				4'h8:    frameByte = CH_E;
				4'ha:    frameByte = CH_CR;
				4'hb:    frameByte = CH_LF;
				default: frameByte = CH_SP;
			endcase
		end
	endfunction : frameByte

	// latest reading, shared by the frame, two-wire, alarm and pulse outputs
	logic [6:0] meas_r;
	logic       newMeas_r;
	logic [7:0] measSeq_r;
	logic       pushBusy_r;
	logic [3:0] pushIdx_r;
	logic [6:0] snap_r;
	logic       snapPpm_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meas_r    <= '0;
			measSeq_r <= '0;
		end else if (measValid) begin
			meas_r    <= (measLel > FULL_RANGE) ? FULL_RANGE : measLel;
			measSeq_r <= measSeq_r + 1'b1;
		end
	end

	// frame builder into the FIFO
	logic       fInReady;
	logic       fOutValid;
	logic       fOutReady;
	logic [7:0] fOutData;
	logic [7:0] fInData;
	assign fInData = frameByte(pushIdx_r, snap_r, snapPpm_r);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			newMeas_r  <= 1'b0;
			pushBusy_r <= 1'b0;
			pushIdx_r  <= '0;
			snap_r     <= '0;
			snapPpm_r  <= 1'b0;
		end else begin
			if (measValid) newMeas_r <= 1'b1;
			else if (!pushBusy_r && newMeas_r) newMeas_r <= 1'b0;
			if (!pushBusy_r && newMeas_r) begin
				pushBusy_r <= 1'b1;
				pushIdx_r  <= '0;
				snap_r     <= meas_r;
				snapPpm_r  <= ppmMode;
			end else if (pushBusy_r && fInReady) begin
				pushIdx_r <= pushIdx_r + 1'b1;
				if (pushIdx_r == FRAME_LEN - 1'b1) pushBusy_r <= 1'b0;
			end
		end
	end

	gsoi_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clock    (clock),
		.rst_n    (rst_n),
		.inValid  (pushBusy_r),
		.inReady  (fInReady),
		.inData   (fInData),
		.outValid (fOutValid),
		.outReady (fOutReady),
		.outData  (fOutData)
	);

	// serial transmitter, 8N1
	logic        txBusy_r;
	logic [9:0]  txShift_r;
	logic [3:0]  txBit_r;
	logic [11:0] baudCnt_r;
	logic [11:0] baudTop_r;
	assign fOutReady = !txBusy_r;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			txBusy_r  <= 1'b0;
			txShift_r <= '1;
			txBit_r   <= '0;
			baudCnt_r <= '0;
			baudTop_r <= '0;
			txd_r     <= 1'b1;
		end else if (!txBusy_r) begin
			txd_r <= 1'b1;
			if (fOutValid) begin
				txBusy_r  <= 1'b1;
				txShift_r <= {1'b1, fOutData, 1'b0};
				txBit_r   <= '0;
				baudCnt_r <= '0;
				baudTop_r <= baudDiv(baudSel);
				txd_r     <= 1'b0;
			end
		end else if (baudCnt_r == baudTop_r) begin
			baudCnt_r <= '0;
			txBit_r   <= txBit_r + 1'b1;
			txShift_r <= {1'b1, txShift_r[9:1]};
			txd_r     <= txShift_r[1];
			if (txBit_r == UART_BITS - 1'b1) begin
				txBusy_r <= 1'b0;
				txd_r    <= 1'b1;
			end
		end else begin
			baudCnt_r <= baudCnt_r + 1'b1;
		end
	end

	// alarm with hysteresis, drives the open-collector low side
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) alarmOe_r <= 1'b0;
		else if (meas_r > ALARM_ON_LEL) alarmOe_r <= 1'b1;
		else if (meas_r <= ALARM_OFF_LEL) alarmOe_r <= 1'b0;
	end

	// pulse output in ms ticks
	logic [31:0] msCnt_r;
	logic [10:0] pwmMs_r;
	logic [10:0] highMs_r;
	logic        msTick;
	assign msTick = (msCnt_r == 32'(MS_CYCLES - 1));

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			msCnt_r  <= '0;
			pwmMs_r  <= '0;
			highMs_r <= PWM_START_MS;
			pwmOut_r <= 1'b0;
		end else begin
			msCnt_r  <= msTick ? '0 : msCnt_r + 1'b1;
			pwmOut_r <= (pwmMs_r < highMs_r);
			if (msTick) begin
				if (pwmMs_r == PWM_PERIOD_MS - 1'b1) begin
					pwmMs_r  <= '0;
					highMs_r <= 11'(PWM_START_MS + 11'(18'(meas_r) * 18'(PWM_SPAN_MS) / 18'(FULL_RANGE)));
				end else begin
					pwmMs_r <= pwmMs_r + 1'b1;
				end
			end
		end
	end

	// calibration control on a one-second tick
	logic [31:0] secCnt_r;
	logic [6:0]  manualSec_r;
	logic        manualDone_r;
	logic        autoCmdEn_r;
	logic [1:0]  autoStage_r;
	logic [19:0] autoSec_r;
	logic        secTick;
	logic        manualSel;
	logic        bothLow;
	logic        autoEn;
	assign secTick   = (secCnt_r == 32'(SEC_CYCLES - 1));
	assign bothLow   = !manualZeroPin_n && !periodicZeroPin_n;
	assign manualSel = !manualZeroPin_n && periodicZeroPin_n;
	assign autoEn    = !bothLow && !manualSel && (autoCmdEn_r || !periodicZeroPin_n);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			secCnt_r       <= '0;
			manualSec_r    <= '0;
			manualDone_r   <= 1'b0;
			autoCmdEn_r    <= 1'b0;
			autoStage_r    <= '0;
			autoSec_r      <= '0;
			manualActive_r <= 1'b0;
			autoActive_r   <= 1'b0;
			zeroCalReq_r   <= 1'b0;
		end else begin
			secCnt_r       <= secTick ? '0 : secCnt_r + 1'b1;
			manualActive_r <= manualSel;
			autoActive_r   <= autoEn;
			zeroCalReq_r   <= 1'b0;
			if (autoStartCmd && !bothLow) autoCmdEn_r <= 1'b1;
			if (!manualSel) begin
				manualSec_r  <= '0;
				manualDone_r <= 1'b0;
			end else if (secTick && !manualDone_r) begin
				manualSec_r <= manualSec_r + 1'b1;
				if (manualSec_r == 7'(MANUAL_ZERO_SEC - 1)) begin
					manualDone_r <= 1'b1;
					zeroCalReq_r <= 1'b1;
				end
			end
			if (!autoEn) begin
				autoStage_r <= '0;
				autoSec_r   <= '0;
			end else if (secTick) begin
				if (autoSec_r == autoLimit(autoStage_r)) begin
					autoSec_r    <= '0;
					zeroCalReq_r <= 1'b1;
					if (autoStage_r != 2'h2) autoStage_r <= autoStage_r + 1'b1;
				end else begin
					autoSec_r <= autoSec_r + 1'b1;
				end
			end
		end
	end

	// two-wire read slave
	gsoi_i2c_t  i2cState_r;
	logic       sclPrev_r;
	logic       sdaPrev_r;
	logic [3:0] i2cBit_r;
	logic [7:0] i2cShift_r;
	logic       i2cRead_r;
	logic [2:0] i2cIdx_r;
	logic [6:0] i2cMeas_r;
	logic [7:0] i2cSeq_r;
	logic [3:0] i2cStat_r;
	logic       sclRise;
	logic       sclFall;
	logic       busStart;
	logic       busStop;
	logic [7:0] i2cNext;
	assign sclRise  = sclIn && !sclPrev_r;
	assign sclFall  = !sclIn && sclPrev_r;
	assign busStart = sclIn && sclPrev_r && sdaPrev_r && !sdaIn;
	assign busStop  = sclIn && sclPrev_r && !sdaPrev_r && sdaIn;

	function automatic logic [7:0] i2cByte(input logic [2:0] idx, input logic [6:0] v,
		input logic [7:0] seq, input logic [3:0] st);
		logic [14:0] pv;
		logic [7:0]  sum;
		pv  = 15'(v) * PPM_PER_LEL;
		sum = 8'(v) + 8'(pv[14:8]) + pv[7:0] + 8'(st) + seq;
		case (idx)
			3'h0:    i2cByte = 8'(v);
			3'h1:    i2cByte = 8'(pv[14:8]);
			3'h2:    i2cByte = pv[7:0];
			3'h3:    i2cByte = 8'(st);
			3'h4:    i2cByte = seq;
			3'h6:    i2cByte = sum;
			default: i2cByte = 8'h00;
		endcase
	endfunction : i2cByte

	// next byte to send, selected by the read index
	assign i2cNext = i2cByte(i2cIdx_r, i2cMeas_r, i2cSeq_r, i2cStat_r);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			sclPrev_r  <= 1'b1;
			sdaPrev_r  <= 1'b1;
			i2cState_r <= I_IDLE;
			i2cBit_r   <= '0;
			i2cShift_r <= '0;
			i2cRead_r  <= 1'b0;
			i2cIdx_r   <= '0;
			i2cMeas_r  <= '0;
			i2cSeq_r   <= '0;
			i2cStat_r  <= '0;
			sdaOut_r   <= 1'b0;
			sdaOe_r    <= 1'b0;
		end else begin
			sclPrev_r <= sclIn;
			sdaPrev_r <= sdaIn;
			if (busStart) begin
				i2cState_r <= I_ADDR;
				i2cBit_r   <= '0;
				sdaOe_r    <= 1'b0;
			end else if (busStop) begin
				i2cState_r <= I_IDLE;
				sdaOe_r    <= 1'b0;
			end else begin
				case (i2cState_r)
					I_ADDR, I_CMD: begin
						if (sclRise) begin
							i2cShift_r <= {i2cShift_r[6:0], sdaIn};
							i2cBit_r   <= i2cBit_r + 1'b1;
						end else if (sclFall && i2cBit_r == I2C_BITS) begin
							i2cBit_r <= '0;
							if (i2cState_r == I_CMD) begin
								i2cState_r <= I_ACKC;
								sdaOe_r    <= 1'b1;
								if (i2cShift_r == I2C_CMD_READ) begin
									i2cMeas_r <= meas_r;
									i2cSeq_r  <= measSeq_r;
									i2cStat_r <= {alarmOe_r, ppmMode, manualActive_r, autoActive_r};
								end
							end else if (i2cShift_r[7:1] == I2C_ADDR) begin
								i2cState_r <= I_ACKA;
								i2cRead_r  <= i2cShift_r[0];
								sdaOe_r    <= 1'b1;
							end else begin
								i2cState_r <= I_IDLE;
							end
						end
					end
					I_ACKA, I_ACKC, I_RACK: begin
						if (sclRise && i2cState_r == I_RACK && sdaIn) begin
							i2cState_r <= I_IDLE;
						end else if (sclFall) begin
							i2cBit_r <= '0;
							if (i2cState_r == I_ACKC || !i2cRead_r) begin
								i2cState_r <= I_CMD;
								sdaOe_r    <= 1'b0;
							end else begin
								i2cState_r <= I_TX;
								i2cShift_r <= i2cNext;
								sdaOe_r    <= !i2cNext[7];
								i2cIdx_r   <= (i2cIdx_r == I2C_BYTES - 1'b1) ? '0 : i2cIdx_r + 1'b1;
							end
						end
						if (i2cState_r == I_ACKA && sclFall && !i2cRead_r) i2cIdx_r <= '0;
					end
					I_TX: begin
						if (sclFall) begin
							if (i2cBit_r == I2C_BITS - 1'b1) begin
								i2cState_r <= I_RACK;
								sdaOe_r    <= 1'b0;
							end else begin
								i2cShift_r <= {i2cShift_r[6:0], 1'b0};
								sdaOe_r    <= !i2cShift_r[6];
								i2cBit_r   <= i2cBit_r + 1'b1;
							end
						end
					end
					default: sdaOe_r <= 1'b0;
				endcase
			end
		end
	end

	// checks
	sequence s_txLoad;
		fOutValid && !txBusy_r;
	endsequence
	sequence s_startBit;
		!txd_r && txBusy_r;
	endsequence
	property p_uartStart;
		@(posedge clock) disable iff (!rst_n) s_txLoad |=> s_startBit;
	endproperty
	a_uartStart: assert property (p_uartStart) else $error("no start bit after load");
	property p_alarmOn;
		@(posedge clock) disable iff (!rst_n) (meas_r > ALARM_ON_LEL) |=> alarmOe_r;
	endproperty
	a_alarmOn: assert property (p_alarmOn) else $error("alarm not raised");
	property p_alarmHold;
		@(posedge clock) disable iff (!rst_n)
		(alarmOe_r && meas_r > ALARM_OFF_LEL) |=> alarmOe_r;
	endproperty
	a_alarmHold: assert property (p_alarmHold) else $error("alarm released early");
	property p_normal;
		@(posedge clock) disable iff (!rst_n)
		(manualZeroPin_n && periodicZeroPin_n && !autoCmdEn_r) |=> (!manualActive_r && !autoActive_r);
	endproperty
	a_normal: assert property (p_normal) else $error("calibration active in normal mode");
	property p_manual;
		@(posedge clock) disable iff (!rst_n)
		(!manualZeroPin_n && periodicZeroPin_n) |=> manualActive_r;
	endproperty
	a_manual: assert property (p_manual) else $error("manual zero not entered");
	property p_zeroReq;
		@(posedge clock) disable iff (!rst_n) zeroCalReq_r |-> (manualActive_r || autoActive_r);
	endproperty
	a_zeroReq: assert property (p_zeroReq) else $error("zero request outside calibration");
	property p_pwmRise;
		@(posedge clock) disable iff (!rst_n) $rose(pwmOut_r) |-> ($past(pwmMs_r) == '0);
	endproperty
	a_pwmRise: assert property (p_pwmRise) else $error("pulse rose mid period");
	property p_addrAck;
		@(posedge clock) disable iff (!rst_n) (i2cState_r == I_ACKA) |-> (i2cShift_r[7:1] == I2C_ADDR);
	endproperty
	a_addrAck: assert property (p_addrAck) else $error("acked foreign address");
	property p_frameLen;
		@(posedge clock) disable iff (!rst_n) pushBusy_r |-> (pushIdx_r < FRAME_LEN);
	endproperty
	a_frameLen: assert property (p_frameLen) else $error("frame too long");
	property p_zeroDigit;
		@(posedge clock) disable iff (!rst_n)
		(pushBusy_r && !snapPpm_r && pushIdx_r == 4'h4) |-> (fInData != CH_ZERO);
	endproperty
	a_zeroDigit: assert property (p_zeroDigit) else $error("zero digit not blanked");
endmodule : gsoi_top

//--- verilog/gsoi_pkg.sv
/*
 gsoi_pkg: constants of the gas sensor output interface (timing, characters, thresholds, bus codes).
 assumes a 25 MHz module clock and readings in whole percent of the lower explosive limit.
*/
package gsoi_pkg;
	// clock and time units
	localparam int          CLK_HZ          = 25_000_000;
	localparam int          MS_PER_SEC      = 1000;
	localparam int          SEC_PER_DAY     = 86400;
	// calibration timing
	localparam int          MANUAL_ZERO_SEC = 120;
	localparam int          AUTO_FIRST_DAYS = 2;
	localparam int          AUTO_NEXT_DAYS  = 5;
	localparam int          AUTO_WEEK_DAYS  = 7;
	// serial link
	localparam int          BAUD_DEFAULT    = 38400;
	localparam int          BAUD_SLOW       = 9600;
	localparam int          BAUD_MID        = 19200;
	localparam logic [1:0]  BAUD_SEL_SLOW   = 2'h1;
	localparam logic [1:0]  BAUD_SEL_MID    = 2'h2;
	localparam logic [3:0]  UART_BITS       = 4'ha;
	// text frame
	localparam logic [3:0]  FRAME_LEN       = 4'hc;
	localparam logic [7:0]  CH_SP           = 8'h20;
	localparam logic [7:0]  CH_ZERO         = 8'h30;
	localparam logic [7:0]  CH_ONE          = 8'h31;
	localparam logic [7:0]  CH_PCT          = 8'h25;
	localparam logic [7:0]  CH_L            = 8'h4c;
	localparam logic [7:0]  CH_E            = 8'h45;
	localparam logic [7:0]  CH_P            = 8'h70;
	localparam logic [7:0]  CH_M            = 8'h6d;
	localparam logic [7:0]  CH_CR           = 8'h0d;
	localparam logic [7:0]  CH_LF           = 8'h0a;
	// reading scale and alarm
	localparam logic [6:0]  FULL_RANGE      = 7'h64;
	localparam logic [6:0]  ALARM_ON_LEL    = 7'h19;
	localparam logic [6:0]  ALARM_OFF_LEL   = 7'h0a;
	localparam logic [14:0] PPM_PER_LEL     = 15'h010e;
	// pulse output, in ms
	localparam logic [10:0] PWM_PERIOD_MS   = 11'h7d0;
	localparam logic [10:0] PWM_START_MS    = 11'h002;
	localparam logic [10:0] PWM_SPAN_MS     = 11'h3e8;
	// two-wire slave
	localparam logic [6:0]  I2C_ADDR        = 7'h31;
	localparam logic [7:0]  I2C_CMD_READ    = 8'h52;
	localparam logic [2:0]  I2C_BYTES       = 3'h7;
	localparam logic [3:0]  I2C_BITS        = 4'h8;

	typedef enum logic [6:0] {
		I_IDLE = 7'h01,
		I_ADDR = 7'h02,
		I_ACKA = 7'h04,
		I_CMD  = 7'h08,
		I_ACKC = 7'h10,
		I_TX   = 7'h20,
		I_RACK = 7'h40
	} gsoi_i2c_t;
endpackage : gsoi_pkg

//--- verilog/gsoi_fifo.sv
/*
 gsoi_fifo: flip-flop FIFO with valid/ready on both sides, parameterised width and depth.
 assumes one clock; the reader may stall, which back-pressures the writer through inReady.
*/
`timescale 1ns/1ns
module gsoi_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic             clock,
	input  wire logic             rst_n,
	// fill side
	input  wire logic             inValid,
	output logic                  inReady,
	input  wire logic [WIDTH-1:0] inData,
	// drain side
	output logic                  outValid,
	input  wire logic             outReady,
	output logic      [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	if (DEPTH < 2 || WIDTH < 1) begin : g_badParam
		$error("fifo depth must be at least 2");
	end

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wrPtr_r;
	logic [AW-1:0]    rdPtr_r;
	logic [AW:0]      count_r;
	logic             doWrite;
	logic             doRead;

	function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
	endfunction : nextPtr

	assign inReady  = (count_r != (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign outData  = mem_r[rdPtr_r];
	assign doWrite  = inValid && inReady;
	assign doRead   = outValid && outReady;

	always_ff @(posedge clock) begin
		if (doWrite) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (doWrite) wrPtr_r <= nextPtr(wrPtr_r);
			if (doRead) rdPtr_r <= nextPtr(rdPtr_r);
			if (doWrite && !doRead) count_r <= count_r + 1'b1;
			else if (doRead && !doWrite) count_r <= count_r - 1'b1;
		end
	end

	property p_fullHolds;
		@(posedge clock) disable iff (!rst_n)
		(inValid && !inReady && !outReady) |=> (count_r == (AW+1)'(DEPTH));
	endproperty
	a_fullHolds: assert property (p_fullHolds) else $error("fifo lost its full state");
endmodule : gsoi_fifo

//--- dv/gsoi_host_model.sv
/*
 gsoi_host_model: host board, serial receiver and two-wire master.
 assumes sda has a pull-up and the sensor pulls it low through sdaOe.
*/
`timescale 1ns/1ns
module gsoi_host_model (
	// clock and sensor pins
	input  wire logic clock,
	input  wire logic txd,
	input  wire logic sdaOe,
	// bus levels
	output logic      scl,
	output logic      sda
);
	logic sdaDrv;
	// wired-and of both sides
	assign sda = sdaDrv & ~sdaOe;
	initial begin
		scl = 1'b1;
		sdaDrv = 1'b1;
	end
	// lsb first, 8n1 at 38400
	task automatic uartGet(output logic [7:0] b, output logic ok);
		int n;
		n = 0;
		while (txd !== 1'b0 && n < 90000) begin
			@(negedge clock);
			n++;
		end
		repeat (325) @(negedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (651) @(negedge clock);
			b[i] = txd;
		end
		repeat (651) @(negedge clock);
		ok = (n < 90000) && (txd === 1'b1);
	endtask : uartGet
	task automatic phase(input logic c, input logic d);
		scl <= c;
		sdaDrv <= d;
		repeat (4) @(posedge clock);
	endtask : phase
	// start, address, command, reads; msb first
	task automatic i2cByte(input logic st, input logic [7:0] b, input logic mAck, output logic [7:0] r,
		output logic ack);
		if (st) begin
			phase(1'b1, 1'b1);
			phase(1'b1, 1'b0);
			phase(1'b0, 1'b0);
		end
		for (int i = 7; i >= 0; i--) begin
			phase(1'b0, b[i]);
			phase(1'b1, b[i]);
			r[i] = sda;
		end
		phase(1'b0, mAck);
		phase(1'b1, mAck);
		ack = ~sda;
		phase(1'b0, mAck);
	endtask : i2cByte
	task automatic i2cStop;
		phase(1'b0, 1'b0);
		phase(1'b1, 1'b0);
		phase(1'b1, 1'b1);
	endtask : i2cStop
endmodule : gsoi_host_model

//--- dv/test_gsoi_top.sv
/*
 test_gsoi_top: directed bench for the sensor output block.
 assumes the host model on serial and two-wire pins; short second and ms counts.
*/
`timescale 1ns/1ns
module test_gsoi_top
	import gsoi_pkg::*;
;
	logic       clock, rst_n, measValid, ppmMode, autoStartCmd, manualZeroPin_n, periodicZeroPin_n;
	logic [6:0] measLel;
	logic [1:0] baudSel;
	logic       manualActive_r, autoActive_r, zeroCalReq_r, txd_r, sdaOe_r, alarmOe_r, pwmOut_r, ok;
	logic       sdaOut_r;
	wire        scl, sda;
	int         miscompares, nTests, n;
	logic [7:0] b, r;
	logic [7:0] fr [5] = '{CH_SP, CH_SP, CH_SP, CH_ONE, CH_SP};
	logic [6:0] lv [6] = '{7'h1a, 7'h0b, 7'h0a, 7'h19, 7'h1a, 7'h0a};
	logic [5:0] av = 6'h13;

	gsoi_top #(.SEC_CYCLES(50), .MS_CYCLES(4), .FIFO_DEPTH(16)) i_dut (.clock(clock), .rst_n(rst_n),
		.measValid(measValid), .measLel(measLel), .ppmMode(ppmMode), .baudSel(baudSel),
		.manualZeroPin_n(manualZeroPin_n), .periodicZeroPin_n(periodicZeroPin_n), .autoStartCmd(autoStartCmd),
		.manualActive_r(manualActive_r), .autoActive_r(autoActive_r), .zeroCalReq_r(zeroCalReq_r),
		.txd_r(txd_r), .sclIn(scl), .sdaIn(sda), .sdaOut_r(sdaOut_r), .sdaOe_r(sdaOe_r), .alarmOe_r(alarmOe_r),
		.pwmOut_r(pwmOut_r));
	gsoi_host_model i_host (.clock(clock), .txd(txd_r), .sdaOe(sdaOe_r), .scl(scl), .sda(sda));

	task chk(input logic [15:0] got, input logic [15:0] exp);
		nTests++;
		if (got !== exp) begin
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk
	task stop_test;
		$display("%0d compares, %0d mismatches", nTests, miscompares);
		if (miscompares == 0 && nTests > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	task meas(input logic [6:0] v);
		@(posedge clock);
		measValid <= 1'b1;
		measLel <= v;
		@(posedge clock);
		measValid <= 1'b0;
	endtask : meas
	// cycles while the watched output holds v, bounded
	task runLen(input int sel, input logic v, output int cnt);
		cnt = 0;
		while (((sel == 0) ? pwmOut_r : zeroCalReq_r) === v) begin
			@(negedge clock);
			cnt++;
			if (cnt > 20000) begin
				miscompares++;
				stop_test();
			end
		end
	endtask : runLen

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	initial begin
		rst_n = 1'b0;
		measValid = 1'b0;
		measLel = 7'h00;
		ppmMode = 1'b0;
		baudSel = 2'h0;
		autoStartCmd = 1'b0;
		manualZeroPin_n = 1'b1;
		periodicZeroPin_n = 1'b1;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(negedge clock);
		chk({txd_r, sdaOut_r, sdaOe_r, alarmOe_r, pwmOut_r, zeroCalReq_r, manualActive_r, autoActive_r}, 16'h0080);
		$display("test reset done");
		meas(7'h0a);
		for (int i = 0; i < 5; i++) begin
			i_host.uartGet(b, ok);
			chk({ok, b}, {1'b1, fr[i]});
		end
		$display("test frame done");
		foreach (lv[i]) begin
			meas(lv[i]);
			repeat (4) @(negedge clock);
			chk(alarmOe_r, av[i]);
		end
		$display("test alarm done");
		meas(7'h25);
		i_host.i2cByte(1'b1, 8'h62, 1'b1, r, ok);
		chk(ok, 1'b1);
		i_host.i2cByte(1'b0, I2C_CMD_READ, 1'b1, r, ok);
		chk(ok, 1'b1);
		i_host.i2cStop();
		i_host.i2cByte(1'b1, 8'h63, 1'b1, r, ok);
		chk(ok, 1'b1);
		repeat (4) @(posedge clock);
		i_host.i2cByte(1'b0, 8'hff, 1'b1, r, ok);
		chk(r, 8'h25);
		i_host.i2cStop();
		i_host.i2cByte(1'b1, 8'h64, 1'b1, r, ok);
		chk(ok, 1'b0);
		i_host.i2cStop();
		$display("test two-wire done");
		meas(7'h32);
		runLen(0, 1'b1, n);
		runLen(0, 1'b0, n);
		runLen(0, 1'b1, n);
		chk(n[15:0], 16'h07d8);
		runLen(0, 1'b0, n);
		chk(n[15:0], 16'h1768);
		$display("test pulse done");
		@(posedge clock);
		manualZeroPin_n <= 1'b0;
		repeat (2) @(negedge clock);
		chk(manualActive_r, 1'b1);
		runLen(1, 1'b0, n);
		chk(n > 5900 && n < 6100, 1'b1);
		@(posedge clock);
		manualZeroPin_n <= 1'b1;
		periodicZeroPin_n <= 1'b0;
		repeat (2) @(negedge clock);
		chk({manualActive_r, autoActive_r}, 2'h1);
		@(posedge clock);
		periodicZeroPin_n <= 1'b1;
		repeat (2) @(negedge clock);
		chk({manualActive_r, autoActive_r}, 2'h0);
		@(posedge clock);
		autoStartCmd <= 1'b1;
		@(posedge clock);
		autoStartCmd <= 1'b0;
		repeat (3) @(negedge clock);
		chk(autoActive_r, 1'b1);
		$display("test calibration done");
		stop_test();
	end
endmodule : test_gsoi_top
